/* testbench/host_model.sv */
// Two-wire bus master model for the sensor serial pins
`timescale 1ns/1ns
`default_nettype none
module host_model
(
    // Clock and resolved data wire
    input  wire logic clock,
    input  wire logic sda_line,
    // Pins, data released when high
    output var  logic scl,
    output var  logic sda_o
);
    initial {scl, sda_o} = 2'b11;
    // Quarter bit; keeps scl low 16 cycles, slave needs 4
    task automatic hp();
        repeat (8) @(posedge clock);
        #1;
    endtask
    // Start or repeated start
    task automatic start();
        sda_o = 1'b1;
        hp();
        scl = 1'b1;
        hp();
        sda_o = 1'b0;
        hp();
        scl = 1'b0;
    endtask
    // Stop
    task automatic stop();
        hp();
        sda_o = 1'b0;
        hp();
        scl = 1'b1;
        hp();
        sda_o = 1'b1;
        hp();
    endtask
    // One bit; data moves only while scl is low
    task automatic bit_io(input logic b, output logic r);
        hp();
        sda_o = b;
        hp();
        scl = 1'b1;
        hp();
        r = sda_line;
        hp();
        scl = 1'b0;
    endtask
    // Byte MSB first plus acknowledge bit
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(last, r);
        ack = ~r;
    endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the global control register
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import sensor_ctrl_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic standby_pin = 1'b0;
    logic frame_start = 1'b0;
    logic geom_change = 1'b0;
    logic scl, sda_o, sda_line, sda_oe_r, cfg_apply_r, cfg_pending_r;
    logic frame_show_r, restart_r, low_power_r, out_en_r, core_rst_r;
    logic ack;
    reg_wr_t rw, rw_l;
    logic [15:0] d;
    int   errors = 0, compares = 0, cycles = 0, n_apply = 0, n_rst = 0;
    // Open-drain wire with pull-up
    assign sda_line = (sda_oe_r | ~sda_o) ? 1'b0 : 1'b1;
    always #2 clock = ~clock;
    host_model u_host_model (.clock, .sda_line, .scl, .sda_o);
    sensor_global_ctrl u_sensor_global_ctrl (.clock, .rst_n, .ce(1'b1), .scl_pin(scl), .sda_in(sda_line),
        .sda_out(), .sda_oe_r, .standby_pin, .frame_start, .geom_change, .ext_rdata(16'h0000),
        .rd_index_r(), .reg_wr_r(rw), .cfg_apply_r, .cfg_pending_r, .frame_show_r, .restart_r,
        .low_power_r, .out_en_r, .core_rst_r);
    // Pulse counters and hang guard
    always @(posedge clock)
    begin
        n_apply += cfg_apply_r;
        n_rst += restart_r;
        if (rw.valid) rw_l = rw;
        cycles++;
        if (cycles == 90000)
        begin
            errors++;
            stop_test();
        end
    end
    task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: word %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: flag %b want %b", $time, got, exp);
        end
    endtask
    // Word write; reserved bits always sent as zero
    task automatic wr(input logic [7:0] a, input logic [7:0] i, input logic [15:0] v);
        logic [7:0] q;
        logic k;
        u_host_model.start();
        u_host_model.xfer(a, 1'b1, q, ack);
        u_host_model.xfer(i, 1'b1, q, k);
        u_host_model.xfer(v[15:8], 1'b1, q, k);
        u_host_model.xfer(v[7:0], 1'b1, q, k);
        u_host_model.stop();
    endtask
    task automatic rd(input logic [7:0] a);
        logic k;
        logic [7:0] q;
        u_host_model.start();
        u_host_model.xfer(a, 1'b1, q, k);
        u_host_model.xfer(8'h0d, 1'b1, q, k);
        u_host_model.start();
        u_host_model.xfer(a | 8'h01, 1'b1, q, k);
        u_host_model.xfer(8'hff, 1'b0, d[15:8], k);
        u_host_model.xfer(8'hff, 1'b1, d[7:0], k);
        u_host_model.stop();
    endtask
    // Frame start, or geometry change when g is set
    task automatic pulse(input logic g);
        @(posedge clock);
        #1;
        {geom_change, frame_start} = {g, ~g};
        @(posedge clock);
        #1;
        {geom_change, frame_start} = 2'b00;
        repeat (4) @(posedge clock);
    endtask
    task automatic t_fields();
        rd(8'hba);
        chk_w(d, 16'h0000);
        chk_b(out_en_r, 1'b1);
        wr(8'hba, 8'h0d, 16'h07d6);
        chk_w(16'(n_rst), 16'h0001);
        chk_b(low_power_r, 1'b1);
        chk_b(out_en_r, 1'b0);
        wr(8'hba, 8'h0d, 16'h0000);
        chk_b(ack, 1'b0);
        rd(8'h90);
        chk_w(d, 16'h07d4);
        wr(8'h90, 8'h0d, 16'h0000);
        chk_b(ack, 1'b1);
        $display("test fields done");
    endtask
    task automatic t_standby();
        standby_pin = 1'b1;
        repeat (5) @(posedge clock);
        chk_b(low_power_r, 1'b1);
        chk_b(out_en_r, 1'b0);
        wr(8'hba, 8'h0d, 16'h04c0);
        rd(8'hba);
        chk_w(d, 16'h00c0);
        chk_b(low_power_r, 1'b0);
        chk_b(out_en_r, 1'b1);
        standby_pin = 1'b0;
        wr(8'hba, 8'h0d, 16'h0000);
        $display("test standby done");
    endtask
    task automatic t_hold();
        int n0;
        wr(8'hba, 8'h0d, 16'h8000);
        wr(8'hba, 8'h05, 16'h1234);
        n0 = n_apply;
        pulse(1'b0);
        chk_w(16'(n_apply - n0), 16'h0000);
        chk_b(cfg_pending_r, 1'b1);
        chk_w(rw_l.data, 16'h1234);
        chk_w(16'(rw_l.index), 16'h0005);
        wr(8'hba, 8'h0d, 16'h0000);
        pulse(1'b0);
        chk_w(16'(n_apply - n0), 16'h0001);
        chk_b(cfg_pending_r, 1'b0);
        $display("test hold done");
    endtask
    task automatic t_bad();
        int n0;
        wr(8'hba, 8'h0d, 16'h0200);
        n0 = n_rst;
        pulse(1'b1);
        pulse(1'b0);
        chk_b(frame_show_r, 1'b0);
        chk_w(16'(n_rst - n0), 16'h0001);
        wr(8'hba, 8'h0d, 16'h0100);
        pulse(1'b1);
        pulse(1'b0);
        chk_b(frame_show_r, 1'b1);
        wr(8'hba, 8'h0d, 16'h0105);
        chk_b(core_rst_r, 1'b1);
        chk_b(low_power_r, 1'b0);
        rd(8'hba);
        chk_w(d, 16'h0001);
        wr(8'hba, 8'h0d, 16'h0000);
        chk_b(core_rst_r, 1'b0);
        $display("test bad frame and soft reset done");
    endtask
    task automatic stop_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clock);
        #1;
        rst_n = 1'b1;
        repeat (4) @(posedge clock);
        t_fields();
        t_standby();
        t_hold();
        t_bad();
        stop_test();
    end
endmodule
`default_nettype wire

/* verilog/frame_update_hold.sv */
// Frame-start release of pending register updates
`timescale 1ns/1ns
`default_nettype none
module frame_update_hold
(
    // Clock, reset, enable
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic ce,
    // Control and events
    input  wire logic frame_start,
    input  wire logic hold,
    input  wire logic soft_rst,
    input  wire logic cfg_write,
    // Apply strobe and pending status
    output var  logic apply_r,
    output var  logic pending_r
);

    // Core copies its shadow set on this strobe
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            apply_r <= 1'b0;
        else if (ce)
            apply_r <= frame_start & ~hold & ~soft_rst; // RQ1 RQ2 RQ3
    end

    // New write wins over a release in the same cycle
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            pending_r <= 1'b0;
        else if (ce)
        begin
            if (soft_rst)
                pending_r <= 1'b0;
            else if (cfg_write)
                pending_r <= 1'b1; // RQ2
            else if (frame_start && !hold)
                pending_r <= 1'b0; // RQ3
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_HOLD_BLOCKS: assert property (ce && hold |=> !apply_r) // RQ2
        else $error("update applied while held");
    AST_RELEASE_APPLIES: assert property (ce && frame_start && !hold && !soft_rst |=> apply_r) // RQ3
        else $error("frame start did not apply updates");
    COV_HELD_RELEASE: cover property (ce && hold ##1 ce && !hold ##[1:200] apply_r);

endmodule
`default_nettype wire

/* verilog/pin_sync2.sv */
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none
module pin_sync2 #(
    parameter int W = 3
)
(
    // Clock, reset, enable
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // Asynchronous pins and their synchronised copies
    input  wire logic [W-1:0] d_async,
    output var  logic [W-1:0] q_r
);

    logic [W-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            q_r    <= '0;
        end
        else if (ce)
        begin
            meta_r <= d_async;
            q_r    <= meta_r;
        end
    end

endmodule
`default_nettype wire

/* verilog/sensor_ctrl_defs.svh */
// Constants for the sensor global control register and its serial port
`ifndef SENSOR_CTRL_DEFS_SVH
`define SENSOR_CTRL_DEFS_SVH

// Register index of the global control register
`define GC_INDEX        8'h0d

// Field positions inside the global control word
`define GC_HOLD         15
`define GC_ADDR_ALT     10
`define GC_AUTO_RESTART 9
`define GC_SHOW_BAD     8
`define GC_PIN_IGNORE   7
`define GC_KEEP_DRIVEN  6
`define GC_OUT_DIS      4
`define GC_SW_LOWPOW    2
`define GC_RESTART      1
`define GC_SOFT_RST     0

// Reset value and the value unlisted bits read as
`define GC_RESET_VAL    16'h0000
`define WORD_ZERO       16'h0000

// Seven-bit slave addresses: 0xba/0xbb by default, 0x90/0x91 alternate
`define SLAVE_ADDR_DFLT 7'h5d
`define SLAVE_ADDR_ALT  7'h48

// Serial byte framing
`define BYTE_BITS       4'h8
`define BIT_FIRST       4'h1
`define BIT_NONE        4'h0
`define IDX_STEP        8'h01
`define SDA_LOW         1'b0

`endif

/* verilog/sensor_ctrl_pkg.sv */
// Types shared by the sensor global control logic
`default_nettype none
package sensor_ctrl_pkg;

    // Serial slave byte phase
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_REG  = 3'b010,
        S_WHI  = 3'b011,
        S_WLO  = 3'b100,
        S_RHI  = 3'b101,
        S_RLO  = 3'b110
    } tws_state_t;

    // Live fields of the global control register
    typedef struct packed {
        logic hold;
        logic addr_alt;
        logic auto_restart;
        logic show_bad;
        logic pin_ignore;
        logic keep_driven;
        logic out_dis;
        logic sw_lowpow;
        logic soft_rst;
    } gctrl_t;

    // Register write passed on to the sensor core
    typedef struct packed {
        logic        valid;
        logic [7:0]  index;
        logic [15:0] data;
    } reg_wr_t;

endpackage
`default_nettype wire

/* verilog/sensor_global_ctrl.sv */
// Global control register of the sensor with its two-wire slave port
// Function
// RQ1: Many register updates take effect at frame start, not at write time.
// RQ2: While hold bit 15 is set, written changes stay pending.
// RQ3: Clearing hold applies all pending changes together at next frame start.
// RQ4: Address-select clear: serial port answers only 0xba and 0xbb.
// RQ5: Address-select bit 10 set: serial port answers 0x90 and 0x91.
// RQ6: Writes to address-select are ignored while the power-down pin is asserted.
// RQ7: Auto-restart bit 9 forces a frame restart on every corrupted frame.
// RQ8: Show-corrupt bit 8 outputs all frames; clear outputs good frames only.
// RQ9: First frame after a geometry or timing change counts as corrupted.
// RQ10: Power-down pin enters and leaves low power by default.
// RQ11: Ignore-pin bit 7 stops the pin affecting low power.
// RQ12: Pin tristates outputs unless keep-driven bit 6 is set.
// RQ13: Output-disable bit 4 tristates the output pins regardless of the pin.
// RQ14: Software low-power bit 2 enters low power.
// RQ15: Writing one to restart bit 1 truncates the frame and restarts.
// RQ16: Restart bit is write-one trigger and always reads zero.
// RQ17: Soft-reset bit 0 holds the device in reset, others to defaults.
// RQ18: Clearing soft-reset resumes normal operation.
// RQ19: Host writes reserved bits with defaults; unlisted bits read zero.
`include "sensor_ctrl_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module sensor_global_ctrl
    import sensor_ctrl_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Two-wire serial pins, data is open drain
    input  wire logic        scl_pin,
    input  wire logic        sda_in,
    output wire logic        sda_out,
    output var  logic        sda_oe_r,
    // Power-down pin
    input  wire logic        standby_pin,
    // Sensor core events and register data
    input  wire logic        frame_start,
    input  wire logic        geom_change,
    input  wire logic [15:0] ext_rdata,
    output var  logic [7:0]  rd_index_r,
    output var  reg_wr_t     reg_wr_r,
    // Update release
    output wire logic        cfg_apply_r,
    output wire logic        cfg_pending_r,
    // Global controls
    output var  logic        frame_show_r,
    output var  logic        restart_r,
    output var  logic        low_power_r,
    output var  logic        out_en_r,
    output var  logic        core_rst_r
);

    tws_state_t  state_r;
    gctrl_t      ctrl_r;
    gctrl_t      ctrl_nxt;
    logic        scl_s;
    logic        sda_s;
    logic        standby_s;
    logic        scl_d_r;
    logic        sda_d_r;
    logic        ack_r;
    logic        rnw_r;
    logic        mack_r;
    logic [3:0]  bit_r;
    logic [7:0]  shift_r;
    logic [6:0]  tx_r;
    logic [7:0]  hi_r;
    logic [15:0] rd_word_r;
    logic        bad_next_r;
    logic        frame_bad_r;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_c;
    logic        stop_c;
    logic        rd_c;
    logic        byte_end_c;
    logic        wr_done_c;
    logic        wr_ctrl_c;
    logic        wr_ext_c;
    logic [15:0] wdata_c;
    logic [15:0] rd_src_c;

    // Register index decode, shared by write and read paths
    function automatic logic is_ctrl(input logic [7:0] idx);
        return idx == `GC_INDEX;
    endfunction

    // Word to fields; reserved bits are dropped
    function automatic gctrl_t ctrl_decode(input logic [15:0] w);
        gctrl_t c;
        c.hold         = w[`GC_HOLD];
        c.addr_alt     = w[`GC_ADDR_ALT];
        c.auto_restart = w[`GC_AUTO_RESTART];
        c.show_bad     = w[`GC_SHOW_BAD];
        c.pin_ignore   = w[`GC_PIN_IGNORE];
        c.keep_driven  = w[`GC_KEEP_DRIVEN];
        c.out_dis      = w[`GC_OUT_DIS];
        c.sw_lowpow    = w[`GC_SW_LOWPOW];
        c.soft_rst     = w[`GC_SOFT_RST];
        return c;
    endfunction

    // Fields to readback word; restart and unlisted bits read zero
    function automatic logic [15:0] ctrl_word(input gctrl_t c);
        logic [15:0] w;
        w                   = `WORD_ZERO; // RQ19
        w[`GC_HOLD]         = c.hold;
        w[`GC_ADDR_ALT]     = c.addr_alt;
        w[`GC_AUTO_RESTART] = c.auto_restart;
        w[`GC_SHOW_BAD]     = c.show_bad;
        w[`GC_PIN_IGNORE]   = c.pin_ignore;
        w[`GC_KEEP_DRIVEN]  = c.keep_driven;
        w[`GC_OUT_DIS]      = c.out_dis;
        w[`GC_SW_LOWPOW]    = c.sw_lowpow;
        w[`GC_SOFT_RST]     = c.soft_rst;
        return w; // RQ16
    endfunction

    // Slave address compare against the selected pair
    function automatic logic addr_match(input logic [6:0] a, input logic alt);
        return a == (alt ? `SLAVE_ADDR_ALT : `SLAVE_ADDR_DFLT);
    endfunction

    // Pins arrive from another domain
    pin_sync2 #(
        .W(3)
    ) u_pin_sync (
        .clock   (clock),
        .rst_n   (rst_n),
        .ce      (ce),
        .d_async ({scl_pin, sda_in, standby_pin}),
        .q_r     ({scl_s, sda_s, standby_s})
    );

    // Open drain: only ever pulls low
    assign sda_out = `SDA_LOW;

    // Previous pin levels for edge and start/stop detection
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else if (ce)
        begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // Bus events and transfer decode
    assign scl_rise   = scl_s & ~scl_d_r;
    assign scl_fall   = ~scl_s & scl_d_r;
    assign start_c    = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_c     = scl_s & scl_d_r & ~sda_d_r & sda_s;
    assign rd_c       = (state_r == S_RHI) || (state_r == S_RLO);
    assign byte_end_c = ce & scl_fall & ~ack_r & (bit_r == `BYTE_BITS) & ~start_c & ~stop_c;
    assign wr_done_c  = byte_end_c & (state_r == S_WLO);
    assign wr_ctrl_c  = wr_done_c & is_ctrl(rd_index_r);
    assign wr_ext_c   = wr_done_c & ~is_ctrl(rd_index_r);
    assign wdata_c    = {hi_r, shift_r};
    assign rd_src_c   = is_ctrl(rd_index_r) ? ctrl_word(ctrl_r) : ext_rdata;

    // Two-wire slave: bits in on rising clock, out on falling clock
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r    <= S_IDLE;
            ack_r      <= 1'b0;
            rnw_r      <= 1'b0;
            mack_r     <= 1'b0;
            bit_r      <= `BIT_NONE;
            shift_r    <= '0;
            tx_r       <= '0;
            hi_r       <= '0;
            rd_word_r  <= '0;
            rd_index_r <= '0;
            sda_oe_r   <= 1'b0;
        end
        else if (ce)
        begin
            if (start_c)
            begin
                state_r  <= S_ADDR;
                bit_r    <= `BIT_NONE;
                ack_r    <= 1'b0;
                sda_oe_r <= 1'b0;
            end
            else if (stop_c)
            begin
                state_r  <= S_IDLE;
                ack_r    <= 1'b0;
                sda_oe_r <= 1'b0;
            end
            else if (state_r != S_IDLE && scl_rise)
            begin
                if (ack_r)
                    mack_r <= ~sda_s; // Master acks by pulling low
                else if (!rd_c)
                begin
                    shift_r <= {shift_r[6:0], sda_s};
                    bit_r   <= bit_r + `BIT_FIRST;
                end
            end
            else if (state_r != S_IDLE && scl_fall)
            begin
                if (byte_end_c)
                begin
                    ack_r <= 1'b1;
                    bit_r <= `BIT_NONE;
                    unique case (state_r)
                        S_ADDR:
                        begin
                            if (addr_match(shift_r[7:1], ctrl_r.addr_alt)) // RQ4 RQ5
                            begin
                                sda_oe_r <= 1'b1;
                                rnw_r    <= shift_r[0];
                            end
                            else
                                state_r <= S_IDLE;
                        end
                        S_REG:
                        begin
                            rd_index_r <= shift_r;
                            sda_oe_r   <= 1'b1;
                        end
                        S_WHI:
                        begin
                            hi_r     <= shift_r;
                            sda_oe_r <= 1'b1;
                        end
                        S_WLO:   sda_oe_r <= 1'b1;
                        default: sda_oe_r <= 1'b0; // Release for master ack
                    endcase
                end
                else if (ack_r)
                begin
                    ack_r    <= 1'b0;
                    sda_oe_r <= 1'b0;
                    unique case (state_r)
                        S_ADDR:
                        begin
                            if (rnw_r)
                            begin
                                state_r   <= S_RHI;
                                rd_word_r <= rd_src_c;
                                sda_oe_r  <= ~rd_src_c[15];
                                tx_r      <= rd_src_c[14:8];
                                bit_r     <= `BIT_FIRST;
                            end
                            else
                                state_r <= S_REG;
                        end
                        S_REG: state_r <= S_WHI;
                        S_WHI: state_r <= S_WLO;
                        S_WLO:
                        begin
                            state_r    <= S_WHI;
                            rd_index_r <= rd_index_r + `IDX_STEP; // Auto-increment
                        end
                        S_RHI:
                        begin
                            if (mack_r)
                            begin
                                state_r    <= S_RLO;
                                sda_oe_r   <= ~rd_word_r[7];
                                tx_r       <= rd_word_r[6:0];
                                bit_r      <= `BIT_FIRST;
                                rd_index_r <= rd_index_r + `IDX_STEP;
                            end
                            else
                                state_r <= S_IDLE;
                        end
                        S_RLO:
                        begin
                            if (mack_r)
                            begin
                                state_r   <= S_RHI;
                                rd_word_r <= rd_src_c;
                                sda_oe_r  <= ~rd_src_c[15];
                                tx_r      <= rd_src_c[14:8];
                                bit_r     <= `BIT_FIRST;
                            end
                            else
                                state_r <= S_IDLE;
                        end
                        default: state_r <= S_IDLE;
                    endcase
                end
                else if (rd_c)
                begin
                    sda_oe_r <= ~tx_r[6];
                    tx_r     <= {tx_r[5:0], 1'b0};
                    bit_r    <= bit_r + `BIT_FIRST;
                end
            end
        end
    end

    // Next control value; soft reset forces every other field to default
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl_c)
        begin
            ctrl_nxt = ctrl_decode(wdata_c);
            if (standby_s)
                ctrl_nxt.addr_alt = ctrl_r.addr_alt; // RQ6
        end
        if (ctrl_nxt.soft_rst)
        begin
            ctrl_nxt          = ctrl_decode(`GC_RESET_VAL); // RQ17
            ctrl_nxt.soft_rst = 1'b1;
        end
    end

    // Control register; a write clearing bit 0 leaves reset
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_r <= ctrl_decode(`GC_RESET_VAL);
        else if (ce)
            ctrl_r <= ctrl_nxt; // RQ18
    end

    // Core register writes leave as one-cycle strobes
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            reg_wr_r <= '0;
        else if (ce)
        begin
            reg_wr_r.valid <= wr_ext_c;
            reg_wr_r.index <= rd_index_r;
            reg_wr_r.data  <= wdata_c;
        end
    end

    // Pending updates released at frame start
    frame_update_hold u_hold (
        .clock       (clock),
        .rst_n       (rst_n),
        .ce          (ce),
        .frame_start (frame_start),
        .hold        (ctrl_r.hold),
        .soft_rst    (ctrl_r.soft_rst),
        .cfg_write   (wr_ext_c),
        .apply_r     (cfg_apply_r),
        .pending_r   (cfg_pending_r)
    );

    // Corrupt-frame tracking; a change marks the frame after it
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bad_next_r  <= 1'b0;
            frame_bad_r <= 1'b0;
        end
        else if (ce)
        begin
            if (ctrl_r.soft_rst)
            begin
                bad_next_r  <= 1'b0;
                frame_bad_r <= 1'b0;
            end
            else if (frame_start)
            begin
                frame_bad_r <= bad_next_r;
                bad_next_r  <= geom_change; // RQ9
            end
            else if (geom_change)
                bad_next_r <= 1'b1; // RQ9
        end
    end

    // Restart strobe: host trigger or automatic on a corrupt frame
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            restart_r <= 1'b0;
        else if (ce)
            restart_r <= (wr_ctrl_c & wdata_c[`GC_RESTART]) // RQ15
                       | (ctrl_r.auto_restart & frame_start & bad_next_r & ~ctrl_r.soft_rst); // RQ7
    end

    // Pin-facing controls, all registered
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            frame_show_r <= 1'b0;
            low_power_r  <= 1'b0;
            out_en_r     <= 1'b0;
            core_rst_r   <= 1'b0;
        end
        else if (ce)
        begin
            frame_show_r <= ~ctrl_r.soft_rst & (~frame_bad_r | ctrl_r.show_bad); // RQ8
            low_power_r  <= ctrl_r.sw_lowpow | (~ctrl_r.pin_ignore & standby_s); // RQ10 RQ11 RQ14
            out_en_r     <= ~ctrl_r.out_dis & (ctrl_r.keep_driven | ~standby_s); // RQ12 RQ13
            core_rst_r   <= ctrl_r.soft_rst; // RQ17 RQ18
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_RESTART_READS_ZERO: assert property (is_ctrl(rd_index_r) |-> rd_src_c[`GC_RESTART] == 1'b0) // RQ16
        else $error("restart bit read back as one");
    AST_ADDR_LOCKED: assert property (ce && standby_s && !ctrl_nxt.soft_rst |=> $stable(ctrl_r.addr_alt)) // RQ6
        else $error("address select changed under power-down pin");
    AST_NO_MATCH_IDLE: assert property (byte_end_c && state_r == S_ADDR
        && !addr_match(shift_r[7:1], ctrl_r.addr_alt) |=> state_r == S_IDLE && !sda_oe_r) // RQ4 RQ5
        else $error("foreign slave address acknowledged");
    AST_AUTO_RESTART: assert property (ce && frame_start && bad_next_r && ctrl_r.auto_restart
        && !ctrl_r.soft_rst |=> restart_r) // RQ7
        else $error("corrupt frame did not force restart");
    AST_HOST_RESTART: assert property (wr_ctrl_c && wdata_c[`GC_RESTART] |=> restart_r ##1 (!restart_r || !ce)) // RQ15
        else $error("restart strobe wrong");
    AST_SUPPRESS_BAD: assert property (ce && frame_bad_r && !ctrl_r.show_bad |=> !frame_show_r) // RQ8
        else $error("corrupt frame shown");
    AST_PIN_LOWPOW: assert property (ce && standby_s && !ctrl_r.pin_ignore |=> low_power_r) // RQ10
        else $error("power-down pin ignored");
    AST_PIN_IGNORED: assert property (ce && ctrl_r.pin_ignore && !ctrl_r.sw_lowpow |=> !low_power_r) // RQ11
        else $error("pin affected low power while ignored");
    AST_SW_LOWPOW: assert property (ce && ctrl_r.sw_lowpow |=> low_power_r) // RQ14
        else $error("software low power not entered");
    AST_HIZ: assert property (ce && (ctrl_r.out_dis || (standby_s && !ctrl_r.keep_driven)) |=> !out_en_r) // RQ12 RQ13
        else $error("outputs driven while disabled");
    AST_SOFT_DEFAULTS: assert property (ctrl_r.soft_rst |-> ctrl_word(ctrl_r) == `GC_RESET_VAL + 16'h0001
        ##1 (core_rst_r || !ce)) // RQ17
        else $error("soft reset left fields set");

    COV_READ_WORD: cover property (state_r == S_RHI ##1 state_r == S_RLO);
    COV_AUTO_RESTART: cover property (restart_r && ctrl_r.auto_restart);
    COV_BAD_HIDDEN: cover property (frame_bad_r && !frame_show_r);
    COV_SOFT_RELEASE: cover property (core_rst_r ##[1:100] !core_rst_r);

endmodule
`default_nettype wire
